// >>> src/dsmd_pkg.sv
// Constants shared by the drive select and motor decode block.
// Assumes an 8-bit host data path and a 10-bit I/O address.
`default_nettype none

package dsmd_pkg;
   // Host address decode.
   localparam int ADDR_W = 10;
   localparam logic [9:0] STAT_B_ADDR = 10'h3F1;
   localparam logic [9:0] DOC_ADDR = 10'h3F2;
   localparam logic [9:0] TUS_ADDR = 10'h3F3;
   // Output control register fields and reset values.
   localparam logic [7:0] DOC_RESET = 8'h00;
   localparam int DOC_SEL_LSB = 0;
   localparam int DOC_SEL_MSB = 1;
   localparam int DOC_CORE_RST_BIT = 2;
   localparam int DOC_DMA_GATE_BIT = 3;
   localparam int DOC_MOT_LSB = 4;
   localparam int DOC_MOT_MSB = 7;
   // Tape unit select register.
   localparam logic [1:0] TUS_RESET = 2'h0;
   localparam logic [7:0] TUS_READ_OE = 8'h03;
   // Read bus lane enables.
   localparam logic [7:0] RD_OE_ALL = 8'hFF;
   localparam logic [7:0] RD_OE_NONE = 8'h00;
   localparam logic [7:0] RD_DATA_NONE = 8'h00;
   localparam logic [1:0] STAT_RSVD_ONES = 2'h3;
   localparam logic [2:0] STAT_UNUSED = 3'h0;
   // Drive outputs idle high.
   localparam logic [3:0] DRV_IDLE_N = 4'hF;
   // Software reset stretch: least time rounds up to whole cycles.
   localparam int CLK_PERIOD_NS = 8;
   localparam int SWRST_MIN_NS = 100;
   localparam int SWRST_CYC = (SWRST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SWRST_CNT_W = 4;
   localparam logic [3:0] SWRST_LOAD = 4'(SWRST_CYC);
   localparam logic [3:0] SWRST_ZERO = 4'h0;
   localparam logic [3:0] SWRST_ONE = 4'h1;
endpackage : dsmd_pkg

`default_nettype wire

// >>> src/dsmd_drv_if.sv
// Carries the register fields to the drive decoder and its outputs back.
// Assumes the decoder is purely combinational.
`default_nettype none

interface dsmd_drv_if;
   logic [1:0] code;
   logic [3:0] mot;
   logic swap;
   logic ext;
   logic [3:0] sel_n;
   logic [3:0] mtr_n;
   modport ctl (output code, output mot, output swap, output ext, input sel_n, input mtr_n);
   modport dec (input code, input mot, input swap, input ext, output sel_n, output mtr_n);
endinterface : dsmd_drv_if

`default_nettype wire

// >>> src/dsmd_sync.sv
// Three-stage synchroniser for pin inputs.
// Assumes the inputs are slow levels; a change is taken once stages two and three agree.
`default_nettype none

module dsmd_sync #(
   parameter int W = 1
) (
   // Clock.
   input wire logic clk,
   // Pin side and synchronised side.
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;

   // The chain is left unreset so straps are valid during a host reset.
   always_ff @(posedge clk) begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
   end

   // Each bit updates only when the two settled stages agree.
   always_ff @(posedge clk) begin
      for (int i = 0; i < W; i++) begin
         if (s2_reg[i] == s3_reg[i]) begin
            q[i] <= s3_reg[i];
         end
      end
   end
endmodule : dsmd_sync

`default_nettype wire

// >>> src/dsmd_decode.sv
// Drive select and motor decode, internal four-drive or external 2-to-4.
// Assumes the caller registers the outputs before they reach pins.
`default_nettype none

module dsmd_decode (
   // Fields in, active-low drive lines out.
   dsmd_drv_if.dec d
);
   logic [3:0] sel;
   logic [3:0] mtr;

   // Pick one drive from the code and form the active-low lines.
   always_comb begin
      sel = 4'h0;
      mtr = d.mot;
      for (int i = 0; i < 4; i++) begin
         sel[i] = (d.code == 2'(i)) && d.mot[i];
      end
      if (d.swap) begin
         sel = {sel[3:2], sel[0], sel[1]};
         mtr = {mtr[3:2], mtr[0], mtr[1]};
      end
      if (d.ext) begin
         // Only two select lines exist; the board decodes them.
         d.sel_n = {2'h3, d.code};
         if (d.swap) begin
            d.sel_n[0] = ~(d.code[0] ^ d.code[1]);
         end
         d.mtr_n = {3'h7, ~d.mot[d.code]};
      end else begin
         d.sel_n = ~sel;
         d.mtr_n = ~mtr;
      end
   end
endmodule : dsmd_decode

`default_nettype wire

// >>> src/dsmd_top.sv
// Output control, tape select and drive status registers of a floppy controller.
// Assumes a single 125 MHz clock and a host port with one-cycle strobes.
//
// What this block does
// - Alternate status layout bit 6 shows drive-one select output, active low.
// - Alternate status layout bit 7 shows second-drive-present pin, active low.
// - Output control register holds select, DMA gate, reset, motors; reset clears it.
// - Output control register survives a software reset of the core.
// - Host may write the output control register at any time.
// - Bits 1 and 0 name exactly one of four drives.
// - Bit 2 zero holds the core in reset until a one is written.
// - Software reset leaves the tape register and other control bits untouched.
// - Core reset lasts at least 100 ns, even for back-to-back writes.
// - Legacy mode: bit 3 gates DMA and interrupt pins, else high impedance.
// - Alternate system mode keeps DMA and interrupt pins enabled, even in reset.
// - Bits 4 to 7 drive motor outputs 0 to 3 with internal decode and no swap, one means active.
// - Tape register reads back, has no effect, survives software reset.
// - Normal mode tape read drives bits 1 and 0, others high impedance.
// - Tape code 00 none, 01 unit 1, 10 unit 2, 11 unit 3.
// - Internal decode selects coded drive only while its motor bit is one.
// - A status bit shows drive select bit 0; cleared by hardware reset only.
//
// The plain strobed port was chosen for this implementation.
`default_nettype none

module dsmd_top
   import dsmd_pkg::*;
(
   // Clock and reset.
   input wire logic CLK,
   input wire logic RESETN,
   // Host register port.
   input wire logic [ADDR_W-1:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   output logic [7:0] RDATA_OE,
   // Mode straps.
   input wire logic PS2_MODE,
   input wire logic STAT_ALT,
   input wire logic DRIVE_SWAP,
   input wire logic EXT_DECODE,
   // Drive interface.
   input wire logic SECOND_UNIT_PRESENT_N,
   output logic [3:0] UNIT_SEL_N,
   output logic [3:0] SPINDLE_ON_N,
   // DMA and interrupt pins.
   input wire logic DACK_N,
   input wire logic TC,
   output logic DRQ,
   output logic DRQ_OE,
   output logic FLOPPY_IRQ,
   output logic FLOPPY_IRQ_OE,
   // Controller core side.
   input wire logic CORE_DRQ,
   input wire logic CORE_IRQ,
   output logic CORE_DACK_N,
   output logic CORE_TC,
   output logic CORE_RESET_N
);
   logic [7:0] doc_reg;
   logic [1:0] tus_reg;
   logic [SWRST_CNT_W-1:0] swrst_cnt_reg;
   logic [SWRST_CNT_W-1:0] swrst_cnt_next;
   logic [6:0] pins_s;
   logic ps2_s;
   logic stat_alt_s;
   logic swap_s;
   logic ext_s;
   logic unit2_n_s;
   logic dack_n_s;
   logic tc_s;
   logic doc_wr;
   logic tus_wr;
   logic dma_gate;
   logic [7:0] stat_b;

   dsmd_drv_if drv ();

   // The strap, drive-present and DMA pin inputs come from outside the clock domain.
   dsmd_sync #(
      .W(7)
   ) u_sync (
      .clk(CLK),
      .d({PS2_MODE, STAT_ALT, DRIVE_SWAP, EXT_DECODE, SECOND_UNIT_PRESENT_N, DACK_N, TC}),
      .q(pins_s)
   );

   // Name the synchronised straps.
   assign {ps2_s, stat_alt_s, swap_s, ext_s, unit2_n_s, dack_n_s, tc_s} = pins_s;

   // Register write decode.
   assign doc_wr = WR && (ADDR == DOC_ADDR);
   assign tus_wr = WR && (ADDR == TUS_ADDR);

   // The output control register is written whatever the core is doing.
   // Only the hardware reset clears it; the core reset bit never feeds back here.
   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         doc_reg <= DOC_RESET;
      end else if (doc_wr) begin
         doc_reg <= WDATA;
      end
   end

   // Tape unit code is stored and read back but steers nothing.
   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         tus_reg <= TUS_RESET;
      end else if (tus_wr) begin
         tus_reg <= WDATA[1:0];
      end
   end

   // A write of zero to the core reset bit loads the stretch counter, so that
   // a clear followed at once by a set still gives the core a full pulse.
   always_comb begin
      swrst_cnt_next = swrst_cnt_reg;
      if (doc_wr && !WDATA[DOC_CORE_RST_BIT]) begin
         swrst_cnt_next = SWRST_LOAD;
      end else if (swrst_cnt_reg != SWRST_ZERO) begin
         swrst_cnt_next = swrst_cnt_reg - SWRST_ONE;
      end
   end

   // Stretch counter state.
   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         swrst_cnt_reg <= SWRST_ZERO;
      end else begin
         swrst_cnt_reg <= swrst_cnt_next;
      end
   end

   // Core reset is held by hardware reset, the bit itself, or the stretch.
   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         CORE_RESET_N <= 1'b0;
      end else begin
         CORE_RESET_N <= doc_reg[DOC_CORE_RST_BIT] && (swrst_cnt_reg == SWRST_ZERO);
      end
   end

   // Feed the decoder from the register and the straps.
   assign drv.code = doc_reg[DOC_SEL_MSB:DOC_SEL_LSB];
   assign drv.mot = doc_reg[DOC_MOT_MSB:DOC_MOT_LSB];
   assign drv.swap = swap_s;
   assign drv.ext = ext_s;

   dsmd_decode u_decode (
      .d(drv.dec)
   );

   // Drive lines are registered so the pins never glitch on a code change.
   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         UNIT_SEL_N <= DRV_IDLE_N;
         SPINDLE_ON_N <= DRV_IDLE_N;
      end else begin
         UNIT_SEL_N <= drv.sel_n;
         SPINDLE_ON_N <= drv.mtr_n;
      end
   end

   // In the alternate system mode the pins stay live regardless of bit 3.
   assign dma_gate = ps2_s || doc_reg[DOC_DMA_GATE_BIT];

   // DMA and interrupt gating; the enables follow the mode even during reset,
   // which is why they take the strap rather than a constant there.
   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         DRQ_OE <= ps2_s;
         FLOPPY_IRQ_OE <= ps2_s;
         DRQ <= 1'b0;
         FLOPPY_IRQ <= 1'b0;
         CORE_DACK_N <= 1'b1;
         CORE_TC <= 1'b0;
      end else begin
         DRQ_OE <= dma_gate;
         FLOPPY_IRQ_OE <= dma_gate;
         DRQ <= CORE_DRQ;
         FLOPPY_IRQ <= CORE_IRQ;
         CORE_DACK_N <= dma_gate ? dack_n_s : 1'b1;
         CORE_TC <= dma_gate && tc_s;
      end
   end

   // Status view: normal layout shows motor and select bits, the
   // alternate layout shows the select lines and the second-drive pin.
   always_comb begin
      if (stat_alt_s) begin
         stat_b = {unit2_n_s, UNIT_SEL_N[1], UNIT_SEL_N[0], STAT_UNUSED, UNIT_SEL_N[3], UNIT_SEL_N[2]};
      end else begin
         stat_b = {STAT_RSVD_ONES, doc_reg[DOC_SEL_LSB], STAT_UNUSED, doc_reg[DOC_MOT_LSB+1], doc_reg[DOC_MOT_LSB]};
      end
   end

   // Read data stand for one cycle after the strobe; unmapped reads float.
   always_ff @(posedge CLK) begin
      if (!RESETN || !RD) begin
         RDATA <= RD_DATA_NONE;
         RDATA_OE <= RD_OE_NONE;
      end else begin
         unique case (ADDR)
            STAT_B_ADDR: begin
               RDATA <= stat_b;
               RDATA_OE <= RD_OE_ALL;
            end
            DOC_ADDR: begin
               RDATA <= doc_reg;
               RDATA_OE <= RD_OE_ALL;
            end
            TUS_ADDR: begin
               RDATA <= {6'h00, tus_reg};
               RDATA_OE <= TUS_READ_OE;
            end
            default: begin
               RDATA <= RD_DATA_NONE;
               RDATA_OE <= RD_OE_NONE;
            end
         endcase
      end
   end

   // Length of the current core reset pulse, for checking only.
   logic [7:0] low_run_reg;
   always_ff @(posedge CLK) begin
      if (!RESETN || CORE_RESET_N) begin
         low_run_reg <= 8'h00;
      end else if (low_run_reg != 8'hFF) begin
         low_run_reg <= low_run_reg + 8'h01;
      end
   end

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RESETN);

   a_hw_reset_clears: assert property (@(posedge CLK) disable iff (1'b0)
      !RESETN |=> (doc_reg == DOC_RESET) && !CORE_RESET_N)
      else $error("hardware reset did not clear the control register");

   a_doc_write_any: assert property (doc_wr |=> doc_reg == $past(WDATA))
      else $error("control register write was lost");

   a_doc_kept_swrst: assert property (!CORE_RESET_N && !doc_wr |=> $stable(doc_reg))
      else $error("control register changed during core reset");

   a_swrst_pulse: assert property ($fell(doc_reg[DOC_CORE_RST_BIT]) |-> ##1 !CORE_RESET_N [*8])
      else $error("core reset pulse too short");

   a_swrst_min_len: assert property ($rose(CORE_RESET_N) && $past(RESETN) |-> $past(low_run_reg) >= 8'(SWRST_CYC - 1))
      else $error("core reset shorter than the least duration");

   a_dma_gated: assert property (!ps2_s && !doc_reg[DOC_DMA_GATE_BIT] && $stable(ps2_s)
      |=> !DRQ_OE && !FLOPPY_IRQ_OE && !CORE_TC && CORE_DACK_N)
      else $error("DMA pins live while gated off");

   a_dma_alt_live: assert property (ps2_s && $stable(ps2_s) |=> DRQ_OE && FLOPPY_IRQ_OE)
      else $error("DMA pins disabled in the alternate mode");

   a_one_selected: assert property (!ext_s && $stable(ext_s) |-> $countones(~UNIT_SEL_N) <= 1)
      else $error("more than one drive selected");

   a_motor_follow: assert property (!ext_s && !swap_s && $stable(ext_s) && $stable(swap_s)
      |=> SPINDLE_ON_N == ~$past(doc_reg[DOC_MOT_MSB:DOC_MOT_LSB]))
      else $error("motor outputs do not follow their bits");

   a_tus_kept: assert property (!tus_wr |=> $stable(tus_reg))
      else $error("tape register changed without a write");

   a_tus_read_lanes: assert property (RD && ADDR == TUS_ADDR |=> RDATA_OE == TUS_READ_OE && RDATA[1:0] == $past(tus_reg))
      else $error("tape register read lanes wrong");

   a_stat_alt_bits: assert property (RD && ADDR == STAT_B_ADDR && stat_alt_s
      |=> RDATA[6] == $past(UNIT_SEL_N[1]) && RDATA[7] == $past(unit2_n_s))
      else $error("alternate status bits 6 or 7 wrong");

   a_stat_sel_lsb: assert property (RD && ADDR == STAT_B_ADDR && !stat_alt_s |=> RDATA[5] == $past(doc_reg[0]))
      else $error("status select bit does not follow the register");

   a_read_idle: assert property (!RD |=> RDATA == RD_DATA_NONE && RDATA_OE == RD_OE_NONE)
      else $error("read data driven outside the read cycle");

   a_core_rst_release: assert property (doc_reg[DOC_CORE_RST_BIT] && swrst_cnt_reg == SWRST_ZERO
      |=> CORE_RESET_N)
      else $error("core reset held after the bit was set");

   a_swrst_load: assert property (doc_wr && !WDATA[DOC_CORE_RST_BIT] |=> swrst_cnt_reg == SWRST_LOAD)
      else $error("stretch counter not loaded by a reset write");

   a_sel_motor_on: assert property (!ext_s |=> (~UNIT_SEL_N & SPINDLE_ON_N) == 4'h0)
      else $error("drive selected with its spindle off");

   a_ext_lines: assert property (ext_s
      |=> SPINDLE_ON_N[3:1] == 3'h7 && UNIT_SEL_N[1] == $past(doc_reg[DOC_SEL_MSB]))
      else $error("external decode lines wrong");

   a_gated_pins: assert property (dma_gate
      |=> CORE_DACK_N == $past(dack_n_s) && CORE_TC == $past(tc_s))
      else $error("gated acknowledge or terminal count wrong");

   a_pin_copies: assert property (1'b1 |=> DRQ == $past(CORE_DRQ) && FLOPPY_IRQ == $past(CORE_IRQ))
      else $error("request or interrupt pin lags its source");
endmodule : dsmd_top

`default_nettype wire

// >>> tb/dsmd_drive_model.sv
// Behavioural model of the floppy drives on the select and motor lines.
// Assumes the bench says whether a second drive is fitted.
`default_nettype none

module dsmd_drive_model (
   // Lines from the controller.
   input wire logic [3:0] sel_n,
   input wire logic [3:0] mtr_n,
   // Bench control and drive answers.
   input wire logic fitted,
   output logic present_n,
   output logic multi_sel
);
   timeunit 1ns;
   timeprecision 1ps;
   // A fitted second drive pulls its presence line low.
   assign present_n = ~fitted;
   // Two drives answering at once would fight on the shared cable, and a
   // drive selected with its spindle stopped cannot answer at all.
   assign multi_sel = ($countones(~sel_n) > 1) || ((~sel_n & mtr_n) != 4'h0);
endmodule : dsmd_drive_model

`default_nettype wire

// >>> tb/drive_select_motor_decode_tb.sv
// Self-checking bench for the drive select and motor decode block.
// Assumes the design package and a drive model; 125 MHz clock.
`default_nettype none

module drive_select_motor_decode_tb;
   import dsmd_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, resetn, wr, rd, ps2, alt, swp, ext, fitted, pres_n, multi;
   logic dack_n, tc, drq, drq_oe, irq, irq_oe, core_drq, core_irq, c_dack_n, c_tc, c_rst_n;
   logic [9:0] addr;
   logic [7:0] wdata, rdata, rdata_oe, d, e, mk;
   logic [3:0] sel_n, mtr_n;
   logic [31:0] rs;
   int n_mismatch, samples_checked, cnt;
   logic [7:0] corner [5] = '{8'h1C, 8'h2D, 8'h4E, 8'h8F, 8'h07};

   dsmd_top uut (.CLK(clk), .RESETN(resetn), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
      .RDATA(rdata), .RDATA_OE(rdata_oe), .PS2_MODE(ps2), .STAT_ALT(alt), .DRIVE_SWAP(swp),
      .EXT_DECODE(ext), .SECOND_UNIT_PRESENT_N(pres_n), .UNIT_SEL_N(sel_n), .SPINDLE_ON_N(mtr_n),
      .DACK_N(dack_n), .TC(tc), .DRQ(drq), .DRQ_OE(drq_oe), .FLOPPY_IRQ(irq),
      .FLOPPY_IRQ_OE(irq_oe), .CORE_DRQ(core_drq), .CORE_IRQ(core_irq),
      .CORE_DACK_N(c_dack_n), .CORE_TC(c_tc), .CORE_RESET_N(c_rst_n));
   dsmd_drive_model drives (.sel_n(sel_n), .mtr_n(mtr_n), .fitted(fitted), .present_n(pres_n),
      .multi_sel(multi));

   // Free-running 8 ns clock.
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   // Expected {selects, motors}; external decode defines only the two low selects.
   function automatic logic [7:0] exp_drv(input logic [7:0] v, input logic sw, input logic ex);
      logic [3:0] s;
      logic [3:0] m;
      logic [1:0] c;
      c = v[1:0];
      s = 4'hF;
      m = ~v[7:4];
      if (ex) begin
         s[1:0] = sw ? {c[1], ~(c[0] ^ c[1])} : c;
         m = {3'b111, ~v[4 + c]};
      end else begin
         if (v[4 + c]) s[c] = 1'b0;
         if (sw) begin
            s[1:0] = {s[0], s[1]};
            m[1:0] = {m[0], m[1]};
         end
      end
      return {s, m};
   endfunction : exp_drv

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
         n_mismatch++;
      end
   endtask : chk

   task automatic idle(input int n);
      repeat (n) begin
         @(posedge clk);
         wr <= 1'b0;
         rd <= 1'b0;
      end
   endtask : idle

   // Strobe stays high if the next write follows at once; idle lowers it.
   task automatic wreg(input logic [9:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      rd <= 1'b0;
   endtask : wreg

   // Read data stand only in the cycle after the strobe.
   task automatic rchk(input logic [9:0] a, input logic [7:0] xd, input logic [7:0] xoe);
      @(posedge clk);
      addr <= a;
      wr <= 1'b0;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata, xd, "read data");
      chk(rdata_oe, xoe, "read lane enables");
   endtask : rchk

   task automatic end_of_test;
      $display("Comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : end_of_test

   // Cuts a hang short well beyond the expected run length.
   initial begin
      #(20000 * 8);
      n_mismatch++;
      end_of_test();
   end

   initial begin
      rs = 32'hBB72982F;
      {resetn, wr, rd, alt, swp, ext, fitted, tc, core_drq, core_irq} = '0;
      {ps2, dack_n} = 2'b11;
      addr = '0;
      wdata = '0;
      repeat (6) @(posedge clk);
      #1;
      chk({7'h0, drq_oe & irq_oe}, 8'h01, "pins enabled in reset");
      idle(2);
      resetn <= 1'b1;
      rchk(DOC_ADDR, 8'h00, 8'hFF);
      rchk(TUS_ADDR, 8'h00, 8'h03);
      rchk(10'h3F6, 8'h00, 8'h00);
      chk({7'h0, c_rst_n}, 8'h00, "core held after reset");
      // Tape codes read back untouched; only the low two lanes are driven.
      for (int i = 0; i < 4; i++) begin
         rs = lfsr(rs);
         wreg(TUS_ADDR, {rs[7:2], 2'(i)});
         rchk(TUS_ADDR, {6'h0, 2'(i)}, 8'h03);
      end
      // Clear then set the reset bit back to back and time the pulse.
      wreg(DOC_ADDR, 8'h24);
      idle(20);
      wreg(DOC_ADDR, 8'h20);
      wreg(DOC_ADDR, 8'h24);
      cnt = 0;
      repeat (40) begin
         @(posedge clk);
         wr <= 1'b0;
         #1;
         cnt += (c_rst_n === 1'b0);
      end
      chk(8'(cnt), 8'(SWRST_CYC), "core reset length");
      // Enter reset with other bits set in the same write, check they all stick.
      wreg(DOC_ADDR, 8'h31);
      idle(30);
      chk({7'h0, c_rst_n}, 8'h00, "core reset held");
      rchk(DOC_ADDR, 8'h31, 8'hFF);
      rchk(TUS_ADDR, 8'h03, 8'h03);
      wreg(DOC_ADDR, 8'h35);
      idle(16);
      chk({7'h0, c_rst_n}, 8'h01, "core reset released");
      // DMA and interrupt gating for both modes and both gate values.
      for (int k = 0; k < 4; k++) begin
         ps2 <= k[1];
         rs = lfsr(rs);
         {core_drq, core_irq, tc, dack_n} <= {rs[0], rs[1], 1'b1, 1'b0};
         wreg(DOC_ADDR, {4'h0, k[0], 3'h4});
         idle(8);
         e = {7'h0, k[1] | k[0]};
         chk({7'h0, drq_oe}, e, "drq enable");
         chk({7'h0, irq_oe}, e, "irq enable");
         chk({7'h0, c_tc}, e, "gated tc");
         chk({7'h0, c_dack_n}, ~e & 8'h01, "gated ack");
         if (e[0]) chk({6'h0, drq, irq}, {6'h0, rs[0], rs[1]}, "pin copies");
      end
      // Every combination of the status, swap and decode straps with table corners and random register values.
      for (int md = 0; md < 8; md++) begin
         @(posedge clk);
         {alt, swp, ext} <= 3'(md);
         rs = lfsr(rs);
         fitted <= rs[3];
         idle(6);
         for (int i = 0; i < 8; i++) begin
            rs = lfsr(rs);
            d = (i < 5) ? corner[i] : (rs[7:0] | 8'h04);
            wreg(DOC_ADDR, d);
            idle(2);
            #1;
            e = exp_drv(d, md[1], md[0]);
            mk = md[0] ? 8'h3F : 8'hFF;
            chk({sel_n, mtr_n} & mk, e & mk, "drive lines");
            if (!md[0]) chk({7'h0, multi}, 8'h00, "single select");
            rchk(DOC_ADDR, d, 8'hFF);
            if (md[2]) begin
               rchk(STAT_B_ADDR, {~fitted, e[5], e[4], 3'h0, e[7], e[6]}, 8'hFF);
            end else if (!md[2]) begin
               rchk(STAT_B_ADDR, {2'h3, d[0], 3'h0, d[5], d[4]}, 8'hFF);
            end
         end
      end
      // Hardware reset clears the control register in legacy mode too.
      @(posedge clk);
      ps2 <= 1'b0;
      {alt, swp, ext} <= 3'h0;
      resetn <= 1'b0;
      idle(8);
      resetn <= 1'b1;
      rchk(DOC_ADDR, 8'h00, 8'hFF);
      chk({sel_n, mtr_n}, 8'hFF, "lines idle after reset");
      chk({6'h0, drq_oe, irq_oe}, 8'h00, "pins gated after reset");
      end_of_test();
   end
endmodule : drive_select_motor_decode_tb

`default_nettype wire
